// >>> pid_pkg.sv
// Constants, types and timing figures shared by the process regulator files
package pid_pkg;
   // Clock and control period
   localparam int CLK_HZ = 100_000_000;
   localparam int CTRL_PERIOD_US = 1000;
   localparam int CTRL_PERIOD_CYC = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
   // Control periods per 0.01 s and per 0.1 s setting unit
   localparam int PER_PER_CS = 10_000 / CTRL_PERIOD_US;
   localparam int PER_PER_DS = 100_000 / CTRL_PERIOD_US;
   // Differential time unit is 1 ms
   localparam int TD_UNIT_US = 1000;
   // Relative values in 0.01 % steps, 100.00 % full scale
   localparam int REL_FULL = 10000;
   // Proportional gain in 0.1 steps, 100.0 is unity
   localparam int KP_UNITY = 1000;
   // Blend fraction resolution for automatic gain switchover; fraction bits of the filters and setting ramp
   localparam int BLEND_ONE = 256;
   localparam int FRAC_W = 16;
   // Documented defaults and setting maxima
   localparam logic [15:0] REV_CUT_DEF = 16'h00c8;
   localparam logic [15:0] DEV_LIMIT_DEF = 16'h0000;
   localparam logic [15:0] DIFF_LIMIT_DEF = 16'h000a;
   localparam logic [15:0] KP_DEF = 16'h00c8;
   localparam logic [15:0] TI_DEF = 16'h00c8;
   localparam logic [15:0] TD_DEF = 16'h0000;
   localparam logic [15:0] SW_DEV1_DEF = 16'h07d0;
   localparam logic [15:0] SW_DEV2_DEF = 16'h1f40;
   localparam logic [15:0] FILT_TC_MAX = 16'h1770;
   localparam logic [15:0] HOLD_MAX = 16'hfde8;
   localparam logic [15:0] LOSS_TIME_MAX = 16'h00c8;

   // Gain switchover field encoding
   typedef enum logic [1:0] {
      SW_NONE = 2'h0,
      SW_BY_INPUT = 2'h1,
      SW_AUTO = 2'h2
   } sw_mode_t;

   // Regulator phases, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_HOLD = 3'b010,
      ST_REG = 3'b100
   } reg_state_t;

   // One gain group: kp in 0.1, ti in 0.01 s, td in 1 ms
   typedef struct packed {
      logic [15:0] kp;
      logic [15:0] ti;
      logic [15:0] td;
   } pid_gains_t;

   // Configuration; rel = 0.01 %, freq = 0.01 Hz, times as noted
   typedef struct packed {
      logic [15:0] set_target;   // rel
      logic [15:0] ramp_time;    // 0.01 s
      logic [15:0] fb_tc;        // 0.01 s
      logic [15:0] out_tc;       // 0.01 s
      logic [15:0] dev_limit;    // rel
      logic [15:0] diff_limit;   // rel
      logic [15:0] rev_cut;      // freq
      logic rev_prohibit;
      logic [15:0] low_lim;      // freq
      logic [15:0] up_lim;       // freq
      logic [15:0] max_freq;     // freq
      pid_gains_t g1;
      pid_gains_t g2;
      sw_mode_t sw_mode;
      logic [15:0] sw_dev1;      // rel
      logic [15:0] sw_dev2;      // rel
      logic [15:0] init_val;     // rel
      logic [15:0] hold_time;    // 0.01 s
      logic integ_sep_en;
      logic integ_stop_lim;
      logic [15:0] loss_level;   // rel
      logic [15:0] loss_time;    // 0.1 s
      logic stop_op;
      logic dir_reverse;
   } pid_cfg_t;
endpackage : pid_pkg

// >>> pid_lowpass.sv
// First-order low-pass filter updated once per control period
`timescale 1ns/1ns
module pid_lowpass
   import pid_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic signed [W-1:0] x,
   input wire logic [15:0] tc,
   output logic signed [W-1:0] y
);
   logic signed [W+FRAC_W-1:0] acc_reg;
   logic signed [W+FRAC_W+15:0] delta;
   logic signed [W+FRAC_W+15:0] div;

   // Fractional state keeps slow filters from stalling on rounding
   assign delta = (W+FRAC_W+16)'($signed(x) <<< FRAC_W) - (W+FRAC_W+16)'(acc_reg);
   assign div = $signed((W+FRAC_W+16)'(tc) * (W+FRAC_W+16)'(PER_PER_CS) + 1);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         acc_reg <= '0;
      end else if (tick) begin
         if (tc == 16'h0000) begin
            acc_reg <= (W+FRAC_W)'($signed(x) <<< FRAC_W);
         end else begin
            acc_reg <= (W+FRAC_W)'((W+FRAC_W+16)'(acc_reg) + delta / div);
         end
      end
   end

   assign y = acc_reg[W+FRAC_W-1:FRAC_W];
endmodule : pid_lowpass

// >>> pid_gain_blend.sv
// Selects or interpolates the active gain group
`timescale 1ns/1ns
module pid_gain_blend
   import pid_pkg::*;
(
   input pid_gains_t g1,
   input pid_gains_t g2,
   input sw_mode_t mode,
   input wire logic sel_two,
   input wire logic [15:0] abs_err,
   input wire logic [15:0] dev1,
   input wire logic [15:0] dev2,
   output pid_gains_t g
);
   logic [2:0][15:0] a;
   logic [2:0][15:0] b;
   logic [2:0][15:0] gv;
   logic [15:0] frac;

   assign a = g1;
   assign b = g2;

   // Position of the deviation between the two thresholds
   always_comb begin
      if (abs_err <= dev1) begin
         frac = 16'h0000;
      end else if (abs_err >= dev2) begin
         frac = 16'(BLEND_ONE);
      end else begin
         frac = 16'((32'(abs_err - dev1) * 32'(BLEND_ONE)) / 32'(dev2 - dev1));
      end
   end

   // Linear blend of each gain field
   for (genvar k = 0; k < 3; k++) begin : g_blend
      logic signed [31:0] dk;
      assign dk = $signed(32'(b[k])) - $signed(32'(a[k]));
      assign gv[k] = 16'($signed(32'(a[k])) + dk * $signed(32'(frac)) / BLEND_ONE);
   end

   always_comb begin
      case (mode)
         SW_BY_INPUT: g = sel_two ? g2 : g1;
         SW_AUTO: g = gv;
         default: g = g1;
      endcase
   end
endmodule : pid_gain_blend

// >>> process_pid_regulator.sv
// Process regulator: setting ramp, filters, PID terms, limits, start hold, loss fault
//
// Operation
// - Proportional gain 100.0 on full-scale deviation gives maximum frequency.
// - Integral reaches maximum frequency after integral time at full deviation.
// - Differential on feedback change; full change in differential time gives maximum.
// - Reverse output magnitude bounded by reverse cut-off, default 2.00 Hz.
// - Cut-off zero or reversal prohibited: clamp between lower and upper limit.
// - Cut-off nonzero, reversal allowed: clamp between minus cut-off and upper.
// - Deviation below deviation limit holds the output unchanged.
// - Differential output clamped to its range, default 0.10 %.
// - Setting ramps linearly; zero to full scale takes the change time.
// - Feedback low-pass filtered, time constant up to 60 s.
// - Output frequency low-pass filtered, own time constant up to 60 s.
// - Switchover mode: 0 none, 1 by input, 2 automatic by deviation.
// - Input mode: switch input low selects group one, high group two.
// - Automatic: group one below threshold one, two above two, interpolated between.
// - At start output forced to initial value for hold time, then regulate.
// - Integral separation enabled: pause input freezes integral accumulation.
// - Stop-at-limit option freezes integral while output sits at a limit.
// - Feedback below loss level longer than loss time raises loss fault.
// - Loss level zero disables feedback loss judgement.
// - Stop-operation 0 halts regulation at stop, 1 keeps computing.
// - Reverse action inverts error sign.
`timescale 1ns/1ns
module process_pid_regulator
   import pid_pkg::*;
#(
   parameter int PERIOD_CYC = CTRL_PERIOD_CYC
) (
   input wire logic core_clk,
   input wire logic rstn,
   input pid_cfg_t cfg,
   input wire logic [15:0] feedback,
   input wire logic run,
   input wire logic gain_switch_in,
   input wire logic integ_pause_in,
   input wire logic fault_clear,
   output logic signed [15:0] freq_ref,
   output logic out_at_limit,
   output logic holding_init,
   output logic feedback_loss_fault,
   output logic period_tick
);
   localparam int CW = $clog2(PERIOD_CYC + 1);

   logic [CW-1:0] div_reg;
   logic tick_reg;
   reg_state_t state_reg;
   logic run_prev_reg;
   logic [19:0] hold_cnt_reg;
   logic signed [47:0] acc_reg;
   logic signed [47:0] out_raw_reg;
   logic [15:0] fb_prev_reg;
   logic [31:0] set_fix_reg;
   logic [19:0] loss_cnt_reg;
   logic fault_reg;
   logic sat_reg;
   logic signed [15:0] freq_ref_reg;
   logic hold_out_reg;

   logic [15:0] set_eff;
   logic signed [15:0] fb_filt;
   logic signed [15:0] out_filt;
   pid_gains_t g;
   logic signed [47:0] e;
   logic [15:0] abs_err;
   logic signed [47:0] p_term;
   logic signed [47:0] ti_ticks;
   logic signed [47:0] acc_lim;
   logic signed [47:0] acc_sum;
   logic signed [47:0] acc_next;
   logic signed [47:0] i_term;
   logic signed [47:0] dfb;
   logic signed [47:0] d_raw;
   logic signed [47:0] d_term;
   logic signed [47:0] dl;
   logic signed [47:0] f_raw;
   logic signed [47:0] lo;
   logic signed [47:0] hi;
   logic signed [47:0] f_clamp;
   logic signed [47:0] init_freq;
   logic run_start;
   logic active;
   logic freeze;
   logic [31:0] ramp_step;
   logic [31:0] target_fix;

   // Control period divider; all loop arithmetic steps on this pulse
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else if (div_reg == CW'(PERIOD_CYC - 1)) begin
         div_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   // Setting ramp in 16-bit fractional steps so slow ramps still move
   assign target_fix = {cfg.set_target, 16'h0000};
   assign ramp_step = (cfg.ramp_time == 16'h0000) ? 32'h0000_0001 :
      32'((48'(REL_FULL) << FRAC_W) / (48'(cfg.ramp_time) * 48'(PER_PER_CS)));
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         set_fix_reg <= '0;
      end else if (tick_reg) begin
         if (cfg.ramp_time == 16'h0000) begin
            set_fix_reg <= target_fix;
         end else if (set_fix_reg < target_fix) begin
            set_fix_reg <= (target_fix - set_fix_reg > ramp_step) ?
               set_fix_reg + ramp_step : target_fix;
         end else begin
            set_fix_reg <= (set_fix_reg - target_fix > ramp_step) ?
               set_fix_reg - ramp_step : target_fix;
         end
      end
   end
   assign set_eff = set_fix_reg[31:16];

   // Feedback and output filters
   pid_lowpass #(.W(16)) u_fb_filt (
      .core_clk(core_clk),
      .rstn(rstn),
      .tick(tick_reg),
      .x($signed(feedback)),
      .tc(cfg.fb_tc),
      .y(fb_filt)
   );

   pid_lowpass #(.W(16)) u_out_filt (
      .core_clk(core_clk),
      .rstn(rstn),
      .tick(tick_reg),
      .x(16'(out_raw_reg)),
      .tc(cfg.out_tc),
      .y(out_filt)
   );

   pid_gain_blend u_blend (
      .g1(cfg.g1),
      .g2(cfg.g2),
      .mode(cfg.sw_mode),
      .sel_two(gain_switch_in),
      .abs_err(abs_err),
      .dev1(cfg.sw_dev1),
      .dev2(cfg.sw_dev2),
      .g(g)
   );

   // Error and deviation magnitude; reverse action flips the sign
   always_comb begin
      e = $signed(48'(set_eff)) - $signed(48'(fb_filt));
      if (cfg.dir_reverse) begin
         e = -e;
      end
      abs_err = (e < 0) ? 16'(-e) : 16'(e);
   end

   // Proportional, integral and differential terms in relative units
   always_comb begin
      p_term = e * $signed(48'(g.kp)) / KP_UNITY;
      ti_ticks = $signed(48'(g.ti) * 48'(PER_PER_CS));
      if (ti_ticks == 0) begin
         ti_ticks = 48'sd1;
      end
      acc_lim = $signed(48'(REL_FULL)) * ti_ticks;
      acc_sum = acc_reg + e;
      // Accumulator capped at full scale to bound windup
      if (acc_sum > acc_lim) begin
         acc_next = acc_lim;
      end else if (acc_sum < -acc_lim) begin
         acc_next = -acc_lim;
      end else begin
         acc_next = acc_sum;
      end
      i_term = acc_reg / ti_ticks;
      dfb = $signed(48'(fb_filt)) - $signed(48'(fb_prev_reg));
      // Rising feedback reduces forward error, so the term opposes it
      d_raw = (cfg.dir_reverse ? dfb : -dfb) * $signed(48'(g.td)) * TD_UNIT_US
         / CTRL_PERIOD_US;
      dl = $signed(48'(cfg.diff_limit));
      if (d_raw > dl) begin
         d_term = dl;
      end else if (d_raw < -dl) begin
         d_term = -dl;
      end else begin
         d_term = d_raw;
      end
   end

   // Scale to frequency and apply output limits
   always_comb begin
      f_raw = (p_term + i_term + d_term) * $signed(48'(cfg.max_freq)) / REL_FULL;
      hi = $signed(48'(cfg.up_lim));
      if (cfg.rev_cut == 16'h0000 || cfg.rev_prohibit) begin
         lo = $signed(48'(cfg.low_lim));
      end else begin
         lo = -$signed(48'(cfg.rev_cut));
      end
      if (f_raw > hi) begin
         f_clamp = hi;
      end else if (f_raw < lo) begin
         f_clamp = lo;
      end else begin
         f_clamp = f_raw;
      end
      init_freq = $signed(48'(cfg.init_val)) * $signed(48'(cfg.max_freq)) / REL_FULL;
   end

   assign run_start = run && !run_prev_reg;
   assign active = run || cfg.stop_op;
   assign freeze = (cfg.integ_sep_en && integ_pause_in)
      || (cfg.integ_stop_lim && sat_reg);

   // Phase control: idle, initial-value hold, closed loop
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         run_prev_reg <= 1'b0;
         hold_cnt_reg <= '0;
         acc_reg <= '0;
         out_raw_reg <= '0;
         fb_prev_reg <= '0;
         sat_reg <= 1'b0;
      end else if (tick_reg) begin
         run_prev_reg <= run;
         fb_prev_reg <= fb_filt;
         if (run_start) begin
            state_reg <= ST_HOLD;
            hold_cnt_reg <= 20'(32'(cfg.hold_time) * PER_PER_CS);
            out_raw_reg <= init_freq;
            acc_reg <= $signed(48'(cfg.init_val)) * ti_ticks;
            sat_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  acc_reg <= '0;
                  out_raw_reg <= '0;
                  sat_reg <= 1'b0;
                  if (cfg.stop_op) begin
                     state_reg <= ST_REG;
                  end
               end
               ST_HOLD: begin
                  if (!active) begin
                     state_reg <= ST_IDLE;
                  end else if (hold_cnt_reg == 20'h00000) begin
                     state_reg <= ST_REG;
                  end else begin
                     hold_cnt_reg <= hold_cnt_reg - 1'b1;
                  end
               end
               ST_REG: begin
                  if (!active) begin
                     state_reg <= ST_IDLE;
                  end else if (abs_err >= cfg.dev_limit) begin
                     // Inside the dead band terms and output stay frozen
                     if (!freeze) begin
                        acc_reg <= acc_next;
                     end
                     out_raw_reg <= f_clamp;
                     sat_reg <= (f_clamp != f_raw);
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // Feedback loss: a new loss event wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         loss_cnt_reg <= '0;
         fault_reg <= 1'b0;
      end else begin
         if (tick_reg) begin
            if (cfg.loss_level == 16'h0000 || feedback >= cfg.loss_level) begin
               loss_cnt_reg <= '0;
            end else if (loss_cnt_reg != 20'hfffff) begin
               loss_cnt_reg <= loss_cnt_reg + 1'b1;
            end
         end
         if (cfg.loss_level != 16'h0000 &&
            loss_cnt_reg > 20'(32'(cfg.loss_time) * PER_PER_DS)) begin
            fault_reg <= 1'b1;
         end else if (fault_clear) begin
            fault_reg <= 1'b0;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         freq_ref_reg <= '0;
         hold_out_reg <= 1'b0;
      end else begin
         freq_ref_reg <= out_filt;
         hold_out_reg <= (state_reg == ST_HOLD);
      end
   end

   assign freq_ref = freq_ref_reg;
   assign out_at_limit = sat_reg;
   assign holding_init = hold_out_reg;
   assign feedback_loss_fault = fault_reg;
   assign period_tick = tick_reg;
endmodule : process_pid_regulator

// >>> pid_properties.sv
// Concurrent checks on the process regulator ports
`timescale 1ns/1ns
module pid_properties
   import pid_pkg::*;
#(
   parameter int PERIOD_CYC = 20
) (
   input wire logic core_clk,
   input wire logic rstn,
   input pid_cfg_t cfg,
   input wire logic [15:0] feedback,
   input wire logic run,
   input wire logic gain_switch_in,
   input wire logic integ_pause_in,
   input wire logic fault_clear,
   input wire logic signed [15:0] freq_ref,
   input wire logic out_at_limit,
   input wire logic holding_init,
   input wire logic feedback_loss_fault,
   input wire logic period_tick
);
   int gap_reg;
   logic seen_reg;
   logic [1:0] stop_reg;
   logic [1:0] hold_ticks_reg;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Cycles since last tick; the first tick only arms the spacing check
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         gap_reg <= 0;
         seen_reg <= 1'b0;
      end else if (period_tick) begin
         gap_reg <= 0;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 1;
      end
   end
   // Ticks seen in the hold phase; the filtered reference trails the hold value by two
   always_ff @(posedge core_clk) begin
      if (!rstn || !holding_init) begin
         hold_ticks_reg <= 2'h0;
      end else if (period_tick && hold_ticks_reg != 2'h3) begin
         hold_ticks_reg <= hold_ticks_reg + 2'h1;
      end
   end
   // Periods spent stopped without stop operation, saturating at 3
   always_ff @(posedge core_clk) begin
      if (!rstn || run || cfg.stop_op) begin
         stop_reg <= 2'h0;
      end else if (period_tick && stop_reg != 2'h3) begin
         stop_reg <= stop_reg + 2'h1;
      end
   end
   AST_TICK_PULSE: assert property (period_tick |=> !period_tick)
      else $error("tick wider than one cycle");
   AST_TICK_GAP: assert property (period_tick && seen_reg |-> gap_reg == PERIOD_CYC - 1)
      else $error("control period length wrong");
   AST_REF_AFTER_TICK: assert property ($changed(freq_ref) |-> $past(period_tick, 2))
      else $error("reference moved between periods");
   AST_HOLD_VALUE: assert property (hold_ticks_reg >= 2'h2 && cfg.out_tc == 16'h0
      |-> 32'(freq_ref) == (32'(cfg.init_val) * 32'(cfg.max_freq)) / 32'd10000)
      else $error("hold output differs from initial value");
   AST_HOLD_START: assert property ($rose(holding_init) |-> $past(period_tick, 2) && $past(run, 2))
      else $error("hold entered without a start");
   AST_REV_BOUND: assert property (freq_ref < 0 |-> int'(freq_ref) + int'(cfg.rev_cut) >= 0)
      else $error("reverse output beyond cut-off");
   AST_LOSS_OFF: assert property ($rose(feedback_loss_fault) |-> $past(cfg.loss_level) != 16'h0)
      else $error("loss fault with judgement disabled");
   AST_FAULT_STICKY: assert property (feedback_loss_fault && !fault_clear |=> feedback_loss_fault)
      else $error("loss fault dropped without clear");
   // The zero output reaches the pin two cycles after the third stopped tick
   AST_STOP_ZERO: assert property (stop_reg == 2'h3 && $past(stop_reg) == 2'h3
      && cfg.out_tc == 16'h0 |-> freq_ref == 16'sh0)
      else $error("output not zero at stop");
   // Main scenarios reached
   COV_HOLD: cover property ($rose(holding_init));
   COV_FAULT: cover property ($rose(feedback_loss_fault));
   COV_REVERSE: cover property (freq_ref < 0);
endmodule : pid_properties

bind process_pid_regulator pid_properties #(.PERIOD_CYC(PERIOD_CYC)) u_props (
   .core_clk(core_clk), .rstn(rstn), .cfg(cfg), .feedback(feedback), .run(run),
   .gain_switch_in(gain_switch_in), .integ_pause_in(integ_pause_in),
   .fault_clear(fault_clear), .freq_ref(freq_ref), .out_at_limit(out_at_limit),
   .holding_init(holding_init), .feedback_loss_fault(feedback_loss_fault),
   .period_tick(period_tick));

// >>> fb_source.sv
// Feedback source standing in for the sensor channel
`timescale 1ns/1ns
module fb_source (
   input wire logic core_clk,
   input wire logic [15:0] level,
   output logic [15:0] feedback
);
   // Sampled transducer: new level shows just after the clock edge
   initial feedback = 16'h0;
   always @(posedge core_clk) begin
      feedback <= level;
   end
endmodule : fb_source

// >>> tb.sv
// Self-checking bench for the process regulator
`timescale 1ns/1ns
module tb;
   import pid_pkg::*;
   logic core_clk, rstn, run, gain_switch_in, integ_pause_in, fault_clear;
   pid_cfg_t cfg;
   logic [15:0] feedback, fb_level;
   logic signed [15:0] freq_ref;
   logic out_at_limit, holding_init, feedback_loss_fault, period_tick;
   int err_count = 0;
   int checks_done = 0;

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   fb_source u_fb (.core_clk(core_clk), .level(fb_level), .feedback(feedback));

   // Short period keeps hold and loss times small
   process_pid_regulator #(.PERIOD_CYC(20)) u_dut (.core_clk(core_clk), .rstn(rstn),
      .cfg(cfg), .feedback(feedback), .run(run), .gain_switch_in(gain_switch_in),
      .integ_pause_in(integ_pause_in), .fault_clear(fault_clear), .freq_ref(freq_ref),
      .out_at_limit(out_at_limit), .holding_init(holding_init),
      .feedback_loss_fault(feedback_loss_fault), .period_tick(period_tick));

   task automatic results();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   // Wait n periods; the reference settles two cycles after a tick
   task automatic ticks(input int n);
      repeat (n) @(posedge core_clk iff period_tick === 1'b1);
      repeat (3) @(negedge core_clk);
   endtask : ticks

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Integral creep makes some outputs inexact, so a band is checked
   task automatic rng(input int lo, input int hi);
      checks_done++;
      if ($isunknown(freq_ref) || int'(freq_ref) < lo || int'(freq_ref) > hi) begin
         err_count++;
         $display("ERROR freq_ref expected %0d..%0d seen %0d", lo, hi, freq_ref);
      end
   endtask : rng

   initial begin
      rstn = 1'b0;
      run = 1'b0;
      gain_switch_in = 1'b0;
      integ_pause_in = 1'b0;
      fault_clear = 1'b0;
      fb_level = 16'h0;
      cfg = '0;
      cfg.max_freq = 16'h2710;
      cfg.up_lim = 16'h1f40;
      cfg.low_lim = 16'h0064;
      cfg.rev_cut = REV_CUT_DEF;
      cfg.hold_time = 16'h0001;
      cfg.init_val = 16'h09c4;
      cfg.set_target = 16'h2710;
      cfg.g1 = '{16'h01f4, 16'h03e8, 16'h0000};
      cfg.g2 = '{16'h03e8, 16'h03e8, 16'h0000};
      cfg.sw_dev1 = SW_DEV1_DEF;
      cfg.sw_dev2 = SW_DEV2_DEF;
      repeat (10) @(negedge core_clk);
      rstn = 1'b1;
      @(negedge core_clk);
      chk("freq_ref", 16'h0, freq_ref);
      // Start holds a quarter of maximum frequency
      run = 1'b1;
      ticks(3);
      chk("holding_init", 16'h1, {15'h0, holding_init});
      chk("freq_ref", 16'h09c4, freq_ref);
      run = 1'b0;
      ticks(4);
      chk("freq_ref", 16'h0, freq_ref);
      // Integral alone, 0.02 s to full scale, running while stopped
      cfg.g1 = '{16'h0000, 16'h0002, 16'h0000};
      cfg.stop_op = 1'b1;
      ticks(8);
      rng(2000, 3500);
      // Paused integral keeps its sum; a running one would reach 40.00 Hz
      cfg.integ_sep_en = 1'b1;
      integ_pause_in = 1'b1;
      ticks(3);
      chk("freq_ref", 16'h0dac, freq_ref);
      // Clamped at 30.00 Hz with stop-at-limit, the sum stops growing
      integ_pause_in = 1'b0;
      cfg.integ_stop_lim = 1'b1;
      cfg.up_lim = 16'h0bb8;
      ticks(3);
      chk("out_at_limit", 16'h1, {15'h0, out_at_limit});
      chk("freq_ref", 16'h0bb8, freq_ref);
      cfg.integ_stop_lim = 1'b0;
      cfg.up_lim = 16'h1f40;
      ticks(2);
      chk("freq_ref", 16'h0fa0, freq_ref);
      cfg.g1 = '{16'h01f4, 16'h03e8, 16'h0000};
      cfg.stop_op = 1'b0;
      cfg.init_val = 16'h0;
      run = 1'b1;
      ticks(14);
      rng(5000, 5100);
      // Gain group selection in every switchover mode
      cfg.sw_mode = SW_BY_INPUT;
      gain_switch_in = 1'b1;
      ticks(4);
      chk("freq_ref", 16'h1f40, freq_ref);
      chk("out_at_limit", 16'h1, {15'h0, out_at_limit});
      gain_switch_in = 1'b0;
      ticks(4);
      rng(5000, 5200);
      cfg.sw_mode = SW_AUTO;
      ticks(4);
      chk("freq_ref", 16'h1f40, freq_ref);
      cfg.sw_mode = SW_NONE;
      gain_switch_in = 1'b1;
      ticks(4);
      rng(5000, 5200);
      // Deviation inside the dead band freezes the output
      cfg.dev_limit = 16'h2711;
      cfg.set_target = 16'h0;
      fb_level = 16'h2710;
      ticks(4);
      rng(5000, 5300);
      cfg.dev_limit = 16'h0;
      ticks(4);
      chk("freq_ref", 16'hff38, freq_ref);
      cfg.rev_prohibit = 1'b1;
      ticks(4);
      chk("freq_ref", 16'h0064, freq_ref);
      cfg.rev_prohibit = 1'b0;
      cfg.rev_cut = 16'h0;
      ticks(4);
      chk("freq_ref", 16'h0064, freq_ref);
      cfg.rev_cut = REV_CUT_DEF;
      cfg.dir_reverse = 1'b1;
      ticks(4);
      rng(4800, 5200);
      // Feedback loss: off at level zero, then 0.1 s limit
      cfg.dir_reverse = 1'b0;
      fb_level = 16'h0;
      ticks(110);
      chk("loss_fault", 16'h0, {15'h0, feedback_loss_fault});
      cfg.loss_level = 16'h1388;
      cfg.loss_time = 16'h0001;
      ticks(90);
      chk("loss_fault", 16'h0, {15'h0, feedback_loss_fault});
      ticks(20);
      chk("loss_fault", 16'h1, {15'h0, feedback_loss_fault});
      fault_clear = 1'b1;
      ticks(1);
      chk("loss_fault", 16'h1, {15'h0, feedback_loss_fault});
      fb_level = 16'h2710;
      ticks(1);
      chk("loss_fault", 16'h0, {15'h0, feedback_loss_fault});
      fault_clear = 1'b0;
      // Second reset in mid-run
      rstn = 1'b0;
      repeat (5) @(negedge core_clk);
      rstn = 1'b1;
      @(negedge core_clk);
      chk("freq_ref", 16'h0, freq_ref);
      results();
   end

   // Sequence needs about 300 periods of 20 cycles
   initial begin
      repeat (40000) @(posedge core_clk);
      err_count++;
      $display("ERROR watchdog expected done seen hang");
      results();
   end
endmodule : tb
